//--- rtl/xip_priority_one.sv
// Extended interrupt priority register one with per-source priority level outputs.
//
// Summary of operation
// - Bit 7 sets third timer priority high.
// - Bit 6 sets second comparator priority high.
// - Bit 5 sets first comparator priority high.
// - Bit 4 sets counter array priority high.
// - Bit 3 sets conversion done priority high.
// - Bit 2 sets window compare priority high.
module xip_priority_one
    import xip_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    output logic            sfr_rdata_valid,
    output logic            third_timer_priority,
    output logic            second_comparator_priority,
    output logic            first_comparator_priority,
    output logic            counter_array_priority,
    output logic            conversion_done_priority,
    output logic            window_compare_priority,
    output logic            usb_function_priority,
    output logic            smbus_priority
);

    // ********************************************************************
    // Address decode
    // ********************************************************************
    logic       reg_hit;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] prio_r;
    logic [7:0] prio_nxt;
    logic [7:0] rdata_nxt;

    // A write lands only on the matching address; other addresses belong to other blocks.
    assign reg_hit   = (sfr_addr == XIP_PRIO_ONE_ADDR);
    assign reg_wr    = sfr_wr && reg_hit;
    assign reg_rd    = sfr_rd && reg_hit;
    assign prio_nxt  = reg_wr ? sfr_wdata : prio_r;
    assign rdata_nxt = reg_rd ? prio_r : 8'h00;

    // ********************************************************************
    // Storage and read port
    // ********************************************************************
    // The stored byte; a read returns zero off-address so a shared read mux can OR it.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prio_r          <= XIP_PRIO_ONE_RESET;
            sfr_rdata       <= 8'h00;
            sfr_rdata_valid <= 1'b0;
        end else begin
            prio_r          <= prio_nxt;
            sfr_rdata       <= rdata_nxt;
            sfr_rdata_valid <= reg_rd;
        end
    end

    // ********************************************************************
    // Priority level outputs
    // ********************************************************************
    // Levels are registered copies of the next value so they track the register
    // with no lag while still coming straight from flip-flops.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            third_timer_priority       <= 1'b0;
            second_comparator_priority <= 1'b0;
            first_comparator_priority  <= 1'b0;
            counter_array_priority     <= 1'b0;
            conversion_done_priority   <= 1'b0;
            window_compare_priority    <= 1'b0;
            usb_function_priority      <= 1'b0;
            smbus_priority             <= 1'b0;
        end else begin
            third_timer_priority       <= prio_nxt[XIP_THIRD_TIMER_BIT];
            second_comparator_priority <= prio_nxt[XIP_SECOND_CMP_BIT];
            first_comparator_priority  <= prio_nxt[XIP_FIRST_CMP_BIT];
            counter_array_priority     <= prio_nxt[XIP_CNT_ARRAY_BIT];
            conversion_done_priority   <= prio_nxt[XIP_CONV_DONE_BIT];
            window_compare_priority    <= prio_nxt[XIP_WINDOW_BIT];
            usb_function_priority      <= prio_nxt[XIP_USB_BIT];
            smbus_priority             <= prio_nxt[XIP_SMBUS_BIT];
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    // These properties watch only what this block drives. Writes and reads are
    // recognised from the raw strobes and address, not from the decode wires
    // above, so that a broken decode cannot hide behind its own checks.

    // The eight levels gathered into one byte in register order, bit 7 the
    // third timer down to bit 0 the SMBus, so whole-byte checks read like the map.
    logic [7:0] prio_levels;

    assign prio_levels = {third_timer_priority,
                          second_comparator_priority,
                          first_comparator_priority,
                          counter_array_priority,
                          conversion_done_priority,
                          window_compare_priority,
                          usb_function_priority,
                          smbus_priority};

    // A write that lands on this register.
    sequence s_write_hit;
        sfr_wr && (sfr_addr == XIP_PRIO_ONE_ADDR);
    endsequence

    // Any read of this register, with or without a write in the same cycle.
    sequence s_read_hit;
        sfr_rd && (sfr_addr == XIP_PRIO_ONE_ADDR);
    endsequence

    // A read of this register with no write beside it.
    sequence s_read_only_hit;
        sfr_rd && !sfr_wr && (sfr_addr == XIP_PRIO_ONE_ADDR);
    endsequence

    // A write followed at once by a plain read, which must return the new byte.
    sequence s_write_then_read;
        s_write_hit ##1 s_read_only_hit;
    endsequence

    // ********************************************************************
    // Per-source level checks
    // ********************************************************************
    // Each level shows its bit of the written byte from the cycle after the
    // write. The levels feed arbitration directly, so a lag of even one cycle
    // would let a request be ranked at its old level.
    a_timer_level_write: assert property (@(posedge core_clk) disable iff (!resetn)
        s_write_hit |=> third_timer_priority == $past(sfr_wdata[XIP_THIRD_TIMER_BIT]))
        else $error("Third timer level does not follow write.");

    // The second comparator level follows bit 6 of the written byte.
    a_cmp_two_level: assert property (@(posedge core_clk) disable iff (!resetn)
        s_write_hit |=> second_comparator_priority == $past(sfr_wdata[XIP_SECOND_CMP_BIT]))
        else $error("Second comparator level does not follow write.");

    // The first comparator level follows bit 5 of the written byte.
    a_cmp_one_level: assert property (@(posedge core_clk) disable iff (!resetn)
        s_write_hit |=> first_comparator_priority == $past(sfr_wdata[XIP_FIRST_CMP_BIT]))
        else $error("First comparator level does not follow write.");

    // The counter array level follows bit 4 of a write and holds otherwise.
    a_array_level_write: assert property (@(posedge core_clk) disable iff (!resetn)
        s_write_hit |=> counter_array_priority == $past(sfr_wdata[XIP_CNT_ARRAY_BIT]))
        else $error("Counter array level does not follow write.");
    a_array_level_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        !(sfr_wr && sfr_addr == XIP_PRIO_ONE_ADDR) |=> $stable(counter_array_priority))
        else $error("Counter array level changed without a write.");

    // The conversion done level follows bit 3 of the written byte.
    a_conv_level_write: assert property (@(posedge core_clk) disable iff (!resetn)
        s_write_hit |=> conversion_done_priority == $past(sfr_wdata[XIP_CONV_DONE_BIT]))
        else $error("Conversion done level does not follow write.");

    // The window compare level follows bit 2 of the written byte.
    a_window_level_write: assert property (@(posedge core_clk) disable iff (!resetn)
        s_write_hit |=> window_compare_priority == $past(sfr_wdata[XIP_WINDOW_BIT]))
        else $error("Window compare level does not follow write.");

    // The USB and SMBus levels follow the two low bits of the written byte.
    a_low_bits_level: assert property (@(posedge core_clk) disable iff (!resetn)
        s_write_hit |=> usb_function_priority == $past(sfr_wdata[XIP_USB_BIT])
            && smbus_priority == $past(sfr_wdata[XIP_SMBUS_BIT]))
        else $error("USB or SMBus level does not follow write.");

    // ********************************************************************
    // Register port checks
    // ********************************************************************
    // A plain read right after a write returns the byte that was written.
    a_readback_value: assert property (@(posedge core_clk) disable iff (!resetn)
        s_write_then_read |=> sfr_rdata == $past(sfr_wdata, 2) && sfr_rdata_valid)
        else $error("Read back differs from written byte.");

    // A read returns the byte held before its edge, so a write in the same
    // cycle is seen only by the next read.
    a_read_old_value: assert property (@(posedge core_clk) disable iff (!resetn)
        s_read_hit |=> sfr_rdata == $past(prio_levels))
        else $error("Read data is not the byte held before the read.");

    // Every read of this address raises the valid flag for the next cycle.
    a_read_valid_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
        s_read_hit |=> sfr_rdata_valid)
        else $error("Read valid missing after a read.");

    // Without a read of this address the read port stays at zero, which keeps
    // the shared read mux free of stale data from this register.
    a_miss_read_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
        !(sfr_rd && sfr_addr == XIP_PRIO_ONE_ADDR)
        |=> sfr_rdata == 8'h00 && !sfr_rdata_valid)
        else $error("Read port active without a read of this register.");

    // No level may move unless a write hits this address; writes to other
    // registers share the strobe and must leave these bits alone.
    a_levels_hold_idle: assert property (@(posedge core_clk) disable iff (!resetn)
        !(sfr_wr && sfr_addr == XIP_PRIO_ONE_ADDR) |=> $stable(prio_levels))
        else $error("Levels changed without a write to this register.");

    // ********************************************************************
    // Reset checks
    // ********************************************************************
    // While reset is low, every output must sit at its reset value by the next
    // edge. This one has no disable clause, since reset is what it watches; it
    // looks one cycle on so that the first edge of a run, before the reset
    // branch has acted, is never judged.
    a_reset_levels_clear: assert property (@(posedge core_clk)
        !resetn |=> prio_levels == XIP_PRIO_ONE_RESET
            && sfr_rdata == 8'h00 && !sfr_rdata_valid)
        else $error("Outputs not at reset value during reset.");

    // Release of reset must not move any level on its own; the first edge after
    // release leaves the reset value in place unless a write is taken there.
    a_release_levels_quiet: assert property (@(posedge core_clk)
        $rose(resetn) && !(sfr_wr && sfr_addr == XIP_PRIO_ONE_ADDR)
        |=> prio_levels == XIP_PRIO_ONE_RESET)
        else $error("Levels moved at reset release.");

endmodule : xip_priority_one

//--- common/xip_pkg.sv
// Package with the address, field positions and reset value of the priority register.
package xip_pkg;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [7:0] XIP_PRIO_ONE_ADDR  = 8'hF6;
    localparam logic [7:0] XIP_PRIO_ONE_RESET = 8'h00;

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int XIP_THIRD_TIMER_BIT = 7;
    localparam int XIP_SECOND_CMP_BIT  = 6;
    localparam int XIP_FIRST_CMP_BIT   = 5;
    localparam int XIP_CNT_ARRAY_BIT   = 4;
    localparam int XIP_CONV_DONE_BIT   = 3;
    localparam int XIP_WINDOW_BIT      = 2;
    localparam int XIP_USB_BIT         = 1;
    localparam int XIP_SMBUS_BIT       = 0;

endpackage : xip_pkg

//--- bench/tb_top.sv
// Self-checking bench for extended interrupt priority register one.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************************************************
    // Stimulus, scoreboard and checks
    // ********************************************************************
    logic       core_clk   = 1'b0;
    logic       resetn     = 1'b0;
    logic [7:0] sfr_addr   = 8'h00;
    logic       sfr_wr     = 1'b0;
    logic [7:0] sfr_wdata  = 8'h00;
    logic       sfr_rd     = 1'b0;
    logic [7:0] sfr_rdata;
    logic       sfr_rdata_valid;
    wire  [7:0] prio;
    logic [7:0] shadow     = xip_pkg::XIP_PRIO_ONE_RESET;
    logic [7:0] exp_q[$];
    int         mismatches = 0;
    int         tests_run  = 0;
    int         seed       = 43018;
    xip_priority_one u_dut (.core_clk(core_clk), .resetn(resetn), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .sfr_rdata_valid(sfr_rdata_valid), .third_timer_priority(prio[7]),
        .second_comparator_priority(prio[6]), .first_comparator_priority(prio[5]),
        .counter_array_priority(prio[4]), .conversion_done_priority(prio[3]),
        .window_compare_priority(prio[2]), .usb_function_priority(prio[1]),
        .smbus_priority(prio[0]));
    // Free-running core clock at 100 MHz.
    always #5 core_clk = ~core_clk;
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One access cycle; a read queues the value held before any same-cycle write.
    task automatic acc(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
        sfr_wr = wr;
        sfr_rd = rd;
        sfr_addr = a;
        sfr_wdata = d;
        if (rd && a == xip_pkg::XIP_PRIO_ONE_ADDR) exp_q.push_back(shadow);
        if (wr && a == xip_pkg::XIP_PRIO_ONE_ADDR) shadow = d;
        @(negedge core_clk);
        chk("priority levels", prio, shadow);
        if (rd && a != xip_pkg::XIP_PRIO_ONE_ADDR)
            chk("refused read", sfr_rdata | {7'h00, sfr_rdata_valid}, 8'h00);
    endtask : acc
    // Each read answer is matched against the oldest queued expectation.
    always @(negedge core_clk) begin
        if (sfr_rdata_valid === 1'b1)
            chk("read data", sfr_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
    end
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    // Watchdog: the whole sequence needs well under a thousand cycles.
    initial begin
        #20000;
        mismatches++;
        end_sim();
    end
    initial begin
        repeat (6) @(negedge core_clk);
        resetn = 1'b1;
        chk("reset value", prio, xip_pkg::XIP_PRIO_ONE_RESET);
        acc(1'b0, 1'b1, xip_pkg::XIP_PRIO_ONE_ADDR, 8'h00);
        $display("test reset value done");
        // Walking one shows each bit drives only its own source level.
        for (int i = 0; i < 8; i++) acc(1'b1, 1'b1, xip_pkg::XIP_PRIO_ONE_ADDR, 8'h01 << i);
        acc(1'b0, 1'b1, xip_pkg::XIP_PRIO_ONE_ADDR, 8'h00);
        $display("test walking bits done");
        acc(1'b1, 1'b1, 8'hF7, 8'hFF);
        acc(1'b1, 1'b0, 8'hF5, 8'hA5);
        $display("test unmapped access done");
        // Random back-to-back traffic, half of it aimed at the register.
        for (int i = 0; i < 40; i++)
            acc(1'($random(seed)), 1'($random(seed)),
                ($random(seed) & 1) ? xip_pkg::XIP_PRIO_ONE_ADDR : 8'($random(seed)),
                8'($random(seed)));
        acc(1'b0, 1'b0, 8'h00, 8'h00);
        chk("pending reads", 8'(exp_q.size()), 8'h00);
        $display("test random traffic done");
        // An asynchronous reset in mid-run must clear a full register before any edge.
        acc(1'b1, 1'b0, xip_pkg::XIP_PRIO_ONE_ADDR, 8'hFF);
        resetn = 1'b0;
        shadow = xip_pkg::XIP_PRIO_ONE_RESET;
        #1;
        chk("reset levels", prio, shadow);
        @(negedge core_clk);
        resetn = 1'b1;
        acc(1'b0, 1'b1, xip_pkg::XIP_PRIO_ONE_ADDR, 8'h00);
        acc(1'b0, 1'b0, 8'h00, 8'h00);
        chk("reads after reset", 8'(exp_q.size()), 8'h00);
        $display("test mid-run reset done");
        end_sim();
    end
endmodule : tb_top
